/* sep_pkg.sv */
// Shared constants and types of the serial EEPROM command port.
// Assumes a 50 MHz system clock; all serial pins arrive asynchronously.
package sep_pkg;

  // System clock
  localparam int CLK_PERIOD_NS = 20;

  // Least chip-select low time before status may be shown
  localparam int T_DESELECT_MIN_NS = 250;
  localparam int DESELECT_MIN_CYC  = (T_DESELECT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CSL_CNT_W         = 4;

  // Self-timed programming times
  localparam int T_PROG_MS      = 6;
  localparam int T_WRITE_ALL_MS = 15;
  localparam int PROG_CYC       = T_PROG_MS * 1000000 / CLK_PERIOD_NS;
  localparam int WRITE_ALL_CYC  = T_WRITE_ALL_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TCNT_W         = 20;

  // Organisation widths
  localparam int AW_BYTE = 7;
  localparam int DW_BYTE = 8;
  localparam int AW_WORD = 6;
  localparam int DW_WORD = 16;

  // Counter widths
  localparam int BCNT_W = 5;
  localparam int DCNT_W = 4;

  // Opcodes after the start bit
  localparam logic [1:0] OPC_EXT   = 2'h0;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_READ  = 2'h2;
  localparam logic [1:0] OPC_ERASE = 2'h3;

  // Sub-codes of the extended opcode
  localparam logic [1:0] SUB_DISABLE   = 2'h0;
  localparam logic [1:0] SUB_WRITE_ALL = 2'h1;
  localparam logic [1:0] SUB_ERASE_ALL = 2'h2;
  localparam logic [1:0] SUB_ENABLE    = 2'h3;

  typedef struct packed {
    logic cs;
    logic sclk;
    logic si;
  } sep_pins_t;

  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_DATA, ST_READ, ST_DONE} sep_state_t;

  typedef enum logic [2:0] {OP_NONE, OP_ERASE, OP_ERASE_ALL, OP_WRITE, OP_WRITE_ALL} sep_op_t;

endpackage

/* sep_sync.sv */
// Two-flop synchroniser for the serial pin bundle.
// Assumes every bit of the bundle is asynchronous to clk.
module sep_sync (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire sep_pkg::sep_pins_t d,
  output sep_pkg::sep_pins_t      q
);

  sep_pkg::sep_pins_t meta_r;

  // First stage is read only by the second
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

/* sep_prog_timer.sv */
// Self-timed programming cycle counter.
// Assumes the load value is at least one; start is ignored while busy.
module sep_prog_timer #(
  parameter int CNT_W = 20
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] load_cnt,
  output logic                  busy,
  output logic                  done
);

  logic [CNT_W-1:0] cnt_r;

  // Last busy cycle; the caller commits the array on it
  assign done = busy && (cnt_r == CNT_W'(1));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
      busy  <= 1'b0;
    end else if (start && !busy) begin
      cnt_r <= load_cnt;
      busy  <= 1'b1;
    end else if (busy) begin
      cnt_r <= cnt_r - CNT_W'(1);
      busy  <= !done;
    end
  end

endmodule

/* sep_eeprom_port.sv */
// Command port of a small serial EEPROM: start detection, decoding,
// sequential read, self-timed programming and ready/busy status.
// Assumes chip_select, serial_clk and serial_in come from an outside master
// whose serial clock is far slower than clk.
module sep_eeprom_port #(
  parameter bit ORG_WORD         = 1'b0,
  parameter int PROG_CYCLES      = sep_pkg::PROG_CYC,
  parameter int WRITE_ALL_CYCLES = sep_pkg::WRITE_ALL_CYC
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic chip_select,
  input  wire logic serial_clk,
  input  wire logic serial_in,
  output logic      serial_out,
  output logic      serial_out_oe,
  output logic      prog_busy
);

  // Organisation fixes the address, data and command widths and the bit counts
  localparam int AW    = ORG_WORD ? sep_pkg::AW_WORD : sep_pkg::AW_BYTE;
  localparam int DW    = ORG_WORD ? sep_pkg::DW_WORD : sep_pkg::DW_BYTE;
  localparam int CMDW  = 2 + AW;
  localparam int DEPTH = 1 << AW;
  localparam int BW    = sep_pkg::BCNT_W;
  localparam int CW    = sep_pkg::DCNT_W;
  localparam int TW    = sep_pkg::TCNT_W;
  localparam int LW    = sep_pkg::CSL_CNT_W;

  localparam logic [BW-1:0] CMD_LAST  = BW'(CMDW - 1);
  localparam logic [BW-1:0] DATA_LAST = BW'(DW - 1);
  localparam logic [CW-1:0] RD_LAST   = CW'(DW - 1);
  localparam logic [LW-1:0] CSL_MIN   = LW'(sep_pkg::DESELECT_MIN_CYC);
  localparam logic [TW-1:0] LD_PROG   = TW'(PROG_CYCLES);
  localparam logic [TW-1:0] LD_WALL   = TW'(WRITE_ALL_CYCLES);

  if (PROG_CYCLES < 1 || WRITE_ALL_CYCLES < PROG_CYCLES ||
      WRITE_ALL_CYCLES >= (1 << TW) || sep_pkg::DESELECT_MIN_CYC >= (1 << LW)) begin : g_bad_cfg
    $error("sep_eeprom_port: programming or deselect counts out of range");
  end

  // The bit counters must reach the last command and data bit
  if (CMDW > (1 << BW) || DW > (1 << CW)) begin : g_bad_cnt
    $error("sep_eeprom_port: bit counters too narrow for the organisation");
  end

  // Pin sampling and edge finding
  sep_pkg::sep_pins_t pins_w;
  sep_pkg::sep_pins_t pins_s;

  assign pins_w = '{cs: chip_select, sclk: serial_clk, si: serial_in};

  sep_sync u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       (pins_w),
    .q       (pins_s)
  );

  logic sclk_prev_r;
  logic cs_prev_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclk_prev_r <= 1'b0;
      cs_prev_r   <= 1'b0;
    end else begin
      sclk_prev_r <= pins_s.sclk;
      cs_prev_r   <= pins_s.cs;
    end
  end

  // Only real rising edges count, so a paused clock never advances anything
  logic edge_w;
  logic cs_rise_w;
  logic cs_fall_w;

  assign edge_w    = pins_s.cs && pins_s.sclk && !sclk_prev_r;
  assign cs_rise_w = pins_s.cs && !cs_prev_r;
  assign cs_fall_w = !pins_s.cs && cs_prev_r;

  // Sequencer state
  sep_pkg::sep_state_t state_r;
  logic [BW-1:0]       bit_cnt_r;
  logic [CMDW-2:0]     cmd_sh_r;
  logic [CMDW-1:0]     cmd_hold_r;
  logic [DW-1:0]       data_sh_r;

  logic prog_done_w;

  // Decode of the complete command field
  logic [CMDW-1:0] cmd_vec_w;
  logic [DW-1:0]   data_vec_w;
  logic [1:0]      opc_w;
  logic [1:0]      sub_w;
  logic [AW-1:0]   adr_w;
  logic            start_w;
  logic            last_cmd_w;
  logic            last_data_w;
  logic            is_read_w;
  logic            is_ext_w;
  logic            needs_data_w;

  // The shifter drops the opcode's upper bit on the last command edge, so
  // the decode at the last data bit reads the held complete field instead
  assign cmd_vec_w    = (state_r == sep_pkg::ST_DATA) ? cmd_hold_r :
                        {cmd_sh_r, pins_s.si};
  assign data_vec_w   = {data_sh_r[DW-2:0], pins_s.si};
  assign opc_w        = cmd_vec_w[CMDW-1 -: 2];
  assign sub_w        = cmd_vec_w[AW-1 -: 2];
  assign adr_w        = cmd_vec_w[AW-1:0];
  // Busy blocks start detection so a new instruction cannot overlap a cycle
  assign start_w      = edge_w && (state_r == sep_pkg::ST_IDLE) && pins_s.si && !prog_busy;
  assign last_cmd_w   = edge_w && (state_r == sep_pkg::ST_CMD) && (bit_cnt_r == CMD_LAST);
  assign last_data_w  = edge_w && (state_r == sep_pkg::ST_DATA) && (bit_cnt_r == DATA_LAST);
  assign is_read_w    = (opc_w == sep_pkg::OPC_READ);
  assign is_ext_w     = (opc_w == sep_pkg::OPC_EXT);
  assign needs_data_w = (opc_w == sep_pkg::OPC_WRITE) ||
                        (is_ext_w && sub_w == sep_pkg::SUB_WRITE_ALL);

  // Sequencer: idle until start, then opcode/address, data, read or done
  always_ff @(posedge clk) begin
    if (sys_rst || !pins_s.cs) begin
      state_r   <= sep_pkg::ST_IDLE;
      bit_cnt_r <= '0;
    end else if (start_w) begin
      state_r   <= sep_pkg::ST_CMD;
      bit_cnt_r <= '0;
    end else if (last_cmd_w) begin
      bit_cnt_r <= '0;
      if (is_read_w) begin
        state_r <= sep_pkg::ST_READ;
      end else if (needs_data_w) begin
        state_r <= sep_pkg::ST_DATA;
      end else begin
        state_r <= sep_pkg::ST_DONE;
      end
    end else if (last_data_w) begin
      state_r <= sep_pkg::ST_DONE;
    end else if (edge_w && (state_r == sep_pkg::ST_CMD || state_r == sep_pkg::ST_DATA)) begin
      bit_cnt_r <= bit_cnt_r + BW'(1);
    end
  end

  // Shift registers; the command field stays put while data arrives
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_sh_r   <= '0;
      cmd_hold_r <= '0;
      data_sh_r  <= '0;
    end else if (edge_w && state_r == sep_pkg::ST_CMD) begin
      cmd_sh_r   <= cmd_vec_w[CMDW-2:0];
      cmd_hold_r <= cmd_vec_w;
    end else if (edge_w && state_r == sep_pkg::ST_DATA) begin
      data_sh_r <= data_vec_w;
    end
  end

  // Program enable latch, off after reset
  logic enable_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable_r <= 1'b0;
    end else if (last_cmd_w && is_ext_w && sub_w == sep_pkg::SUB_ENABLE) begin
      enable_r <= 1'b1;
    end else if (last_cmd_w && is_ext_w && sub_w == sep_pkg::SUB_DISABLE) begin
      enable_r <= 1'b0;
    end
  end

  // Pending and running programming operation
  sep_pkg::sep_op_t op_r;
  logic [AW-1:0]    op_addr_r;
  logic [DW-1:0]    op_data_r;
  sep_pkg::sep_op_t cmd_op_w;
  logic             prog_start_w;
  logic [TW-1:0]    prog_load_w;

  assign cmd_op_w = (opc_w == sep_pkg::OPC_ERASE)                      ? sep_pkg::OP_ERASE :
                    (opc_w == sep_pkg::OPC_WRITE)                      ? sep_pkg::OP_WRITE :
                    (is_ext_w && sub_w == sep_pkg::SUB_ERASE_ALL)      ? sep_pkg::OP_ERASE_ALL :
                    (is_ext_w && sub_w == sep_pkg::SUB_WRITE_ALL)      ? sep_pkg::OP_WRITE_ALL :
                                                                         sep_pkg::OP_NONE;

  // The falling select edge after a complete instruction starts the cycle
  assign prog_start_w = cs_fall_w && (op_r != sep_pkg::OP_NONE) && !prog_busy;
  assign prog_load_w  = (op_r == sep_pkg::OP_WRITE_ALL) ? LD_WALL : LD_PROG;

  always_ff @(posedge clk) begin
    if (sys_rst || prog_done_w) begin
      op_r <= sep_pkg::OP_NONE;
    end else if (last_cmd_w && enable_r && !needs_data_w && !is_read_w) begin
      op_r      <= cmd_op_w;
      op_addr_r <= adr_w;
    end else if (last_data_w && enable_r) begin
      op_r      <= cmd_op_w;
      op_addr_r <= cmd_sh_r[AW-1:0];
      op_data_r <= data_vec_w;
    end else if (start_w) begin
      op_r <= sep_pkg::OP_NONE;
    end
  end

  // Runs on clk alone and ignores chip_select once started
  sep_prog_timer #(
    .CNT_W (TW)
  ) u_timer (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .start    (prog_start_w),
    .load_cnt (prog_load_w),
    .busy     (prog_busy),
    .done     (prog_done_w)
  );

  // Storage array; contents undefined until first programmed
  logic [DW-1:0] mem_r [DEPTH];

  always_ff @(posedge clk) begin
    if (prog_done_w) begin
      case (op_r)
        sep_pkg::OP_ERASE: begin
          mem_r[op_addr_r] <= '1;
        end
        sep_pkg::OP_WRITE: begin
          mem_r[op_addr_r] <= op_data_r;
        end
        sep_pkg::OP_ERASE_ALL: begin
          for (int i = 0; i < DEPTH; i++) mem_r[i] <= '1;
        end
        sep_pkg::OP_WRITE_ALL: begin
          for (int i = 0; i < DEPTH; i++) mem_r[i] <= op_data_r;
        end
        default: begin
        end
      endcase
    end
  end

  // Sequential read pointer and output shifter
  logic [AW-1:0] rd_addr_r;
  logic [DW-1:0] rd_sh_r;
  logic [CW-1:0] rd_cnt_r;
  logic          rd_edge_w;
  logic          rd_wrap_w;

  assign rd_edge_w = edge_w && (state_r == sep_pkg::ST_READ);
  assign rd_wrap_w = rd_edge_w && (rd_cnt_r == RD_LAST);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_addr_r <= '0;
      rd_sh_r   <= '0;
      rd_cnt_r  <= '0;
    end else if (last_cmd_w && is_read_w) begin
      rd_addr_r <= adr_w;
      rd_sh_r   <= mem_r[adr_w];
      rd_cnt_r  <= '0;
    end else if (rd_wrap_w) begin
      // Next location follows with no second leading zero
      rd_addr_r <= rd_addr_r + AW'(1);
      rd_sh_r   <= mem_r[rd_addr_r + AW'(1)];
      rd_cnt_r  <= '0;
    end else if (rd_edge_w) begin
      rd_sh_r  <= {rd_sh_r[DW-2:0], 1'b0};
      rd_cnt_r <= rd_cnt_r + CW'(1);
    end
  end

  // Deselect time and status availability
  logic [LW-1:0] csl_cnt_r;
  logic          avail_r;
  logic          status_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      csl_cnt_r <= '0;
    end else if (!pins_s.cs) begin
      csl_cnt_r <= (csl_cnt_r == CSL_MIN) ? csl_cnt_r : csl_cnt_r + LW'(1);
    end else if (cs_prev_r) begin
      csl_cnt_r <= '0;
    end
  end

  // Status stays available after the cycle until the next start
  always_ff @(posedge clk) begin
    if (sys_rst || start_w) begin
      avail_r <= 1'b0;
    end else if (prog_start_w) begin
      avail_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !pins_s.cs || start_w) begin
      status_r <= 1'b0;
    end else if (cs_rise_w && avail_r && csl_cnt_r == CSL_MIN) begin
      status_r <= 1'b1;
    end
  end

  // Output pin: read data, status, or undriven
  always_ff @(posedge clk) begin
    if (sys_rst || !pins_s.cs || start_w) begin
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end else if (last_cmd_w && is_read_w) begin
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b1;
    end else if (rd_edge_w) begin
      serial_out <= rd_sh_r[DW-1];
    end else if (status_r) begin
      serial_out    <= !prog_busy;
      serial_out_oe <= 1'b1;
    end
  end

endmodule

/* sep_eeprom_port_asserts.sv */
// Checker for the serial EEPROM command port, bound to its top module.
// Assumes the master keeps chip_select low at least 13 clk between frames.
module sep_chk #(
  parameter int PROG_CYCLES      = 50,
  parameter int WRITE_ALL_CYCLES = 120
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic chip_select,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic prog_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  int blen_r;
  int low_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      blen_r <= 0;
      low_r  <= 0;
    end else begin
      blen_r <= prog_busy ? blen_r + 1 : 0;
      low_r  <= chip_select ? 0 : ((low_r < 20) ? low_r + 1 : low_r);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_poll;
    $rose(chip_select) && low_r >= 13 && prog_busy;
  endsequence
  sequence s_ready;
    $fell(prog_busy) ##1 serial_out_oe;
  endsequence
  property p_oe_off;
    !chip_select [*5] |-> !serial_out_oe;
  endproperty
  property p_start_cs;
    $rose(prog_busy) |-> !$past(chip_select, 2);
  endproperty
  property p_len;
    $fell(prog_busy) |-> (blen_r == PROG_CYCLES) || (blen_r == WRITE_ALL_CYCLES);
  endproperty
  property p_busy_low;
    serial_out_oe && prog_busy && $past(prog_busy) |-> !serial_out;
  endproperty
  property p_ready;
    s_ready |-> serial_out;
  endproperty
  property p_read_edge;
    $changed(serial_out) && serial_out_oe && $past(serial_out_oe) && !$past(prog_busy)
      && !$past(prog_busy, 2) |-> $past(serial_clk, 2);
  endproperty
  property p_hold;
    $rose(prog_busy) |-> prog_busy [*8];
  endproperty
  property p_poll;
    s_poll |-> ##[2:6] serial_out_oe;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("output enabled while deselected");
  a_start_cs: assert property (p_start_cs)
    else $error("cycle began without chip select low");
  a_len: assert property (p_len)
    else $error("programming length wrong");
  a_busy_low: assert property (p_busy_low)
    else $error("status high while busy");
  a_ready: assert property (p_ready)
    else $error("status not ready after cycle");
  a_read_edge: assert property (p_read_edge)
    else $error("output changed away from serial clock rise");
  a_hold: assert property (p_hold)
    else $error("cycle cut short");
  a_poll: assert property (p_poll)
    else $error("status not shown on poll");
endmodule

bind sep_eeprom_port sep_chk #(.PROG_CYCLES(PROG_CYCLES), .WRITE_ALL_CYCLES(WRITE_ALL_CYCLES))
  u_sep_chk (.clk(clk), .sys_rst(sys_rst), .chip_select(chip_select),
  .serial_clk(serial_clk), .serial_in(serial_in), .serial_out(serial_out),
  .serial_out_oe(serial_out_oe), .prog_busy(prog_busy));

/* sep_master.sv */
// Serial bus master model: frames, deselect and read-back capture.
// Assumes tasks are called from the bench; serial clock is 8 clk per period.
module sep_master (
  input  wire logic          clk,
  input  wire logic          serial_out,
  input  wire logic          serial_out_oe,
  output sep_pkg::sep_pins_t pins
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] rd;
  logic        line_w;
  // A released line shows the inverse, so a missing enable cannot pass unseen
  assign line_w = serial_out_oe ? serial_out : !serial_out;
  initial begin
    pins = '0;
    rd   = '0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Captures each output bit just before the next rise, well after it settles
  task automatic frame(input logic [31:0] v, input int n);
    tick(1);
    pins.cs <= 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      tick(4);
      pins.sclk <= 1'b0;
      pins.si   <= v[i];
      tick(4);
      rd        <= {rd[30:0], line_w};
      pins.sclk <= 1'b1;
    end
    tick(4);
    pins.sclk <= 1'b0;
    tick(4);
    rd      <= {rd[30:0], line_w};
    pins.si <= ~v[0];
    #1;
  endtask
  task automatic deselect;
    tick(1);
    pins.cs   <= 1'b0;
    pins.sclk <= 1'b0;
    tick(16);
    #1;
  endtask
  task automatic select;
    tick(1);
    pins.cs <= 1'b1;
  endtask
endmodule

/* sep_tb.sv */
// Self-checking bench for the serial EEPROM command port, byte organisation.
// Assumes the master model and the bound checker; cycles shortened to 50 and 120.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PROG = 50;
  localparam int WALL = 120;
  logic               clk;
  logic               sys_rst;
  sep_pkg::sep_pins_t pins;
  logic               serial_out;
  logic               serial_out_oe;
  logic               prog_busy;
  logic               prev_busy;
  logic               oe_seen;
  int                 blen;
  int                 n_errors;
  int                 total_checks;

  sep_master u_master (.clk(clk), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .pins(pins));
  sep_eeprom_port #(.ORG_WORD(1'h0), .PROG_CYCLES(PROG), .WRITE_ALL_CYCLES(WALL))
    u_sep_eeprom_port (.clk(clk), .sys_rst(sys_rst), .chip_select(pins.cs),
    .serial_clk(pins.sclk), .serial_in(pins.si), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .prog_busy(prog_busy));

  initial clk = 1'b0;
  always #10 clk = ~clk;

  always @(posedge clk) begin
    prev_busy <= prog_busy;
    if (prog_busy === 1'b1)
      blen <= (prev_busy === 1'b1) ? blen + 1 : 1;
    if (serial_out_oe === 1'b1)
      oe_seen <= 1'b1;
  end

  function automatic logic [31:0] cmd(input logic [1:0] op, input logic [6:0] a,
                                      input logic [7:0] d);
    return {14'h0000, 1'h1, op, a, d};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (exp !== got) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 1000 && prog_busy !== 1'h0; i++)
      settle(1);
    if (prog_busy !== 1'h0) begin
      n_errors++;
      $display("Error busy timeout expected 0 seen %b", prog_busy);
      print_verdict();
    end
  endtask
  task automatic prog_op(input logic [31:0] v, input int n, input int len, input bit poll);
    u_master.frame(v, n);
    u_master.deselect();
    oe_seen = 1'h0;
    chk("busy", 1, prog_busy);
    if (poll) begin
      u_master.select();
      settle(8);
      chk("status oe", 1, serial_out_oe);
      chk("status busy", 0, serial_out);
    end
    wait_idle();
    settle(2);
    chk("busy len", len, blen);
    if (poll)
      chk("ready", 1, serial_out);
    else
      chk("quiet", 0, oe_seen);
    u_master.deselect();
    chk("oe off", 0, serial_out_oe);
  endtask
  // Three idle clocks before the start bit; data runs on into the next address
  task automatic read_chk(input logic [6:0] a, input logic [16:0] exp);
    u_master.frame((cmd(sep_pkg::OPC_READ, a, 8'h00) >> 8) << 16, 29);
    chk("read oe", 1, serial_out_oe);
    chk("read data", {15'h0000, exp}, u_master.rd & 32'h0001FFFF);
    u_master.deselect();
  endtask
  task automatic locked_write;
    u_master.frame(cmd(sep_pkg::OPC_WRITE, 7'h05, 8'h11), 18);
    u_master.deselect();
    u_master.select();
    settle(8);
    chk("locked busy", 0, prog_busy);
    chk("locked oe", 0, serial_out_oe);
    u_master.deselect();
  endtask
  task automatic t_enable;
    u_master.frame(cmd(sep_pkg::OPC_EXT, {sep_pkg::SUB_ENABLE, 5'h00}, 8'h00) >> 8, 10);
    settle(8);
    chk("enable oe", 0, serial_out_oe);
    u_master.deselect();
  endtask
  task automatic t_erase_all;
    prog_op(cmd(sep_pkg::OPC_EXT, {sep_pkg::SUB_ERASE_ALL, 5'h1F}, 8'h00) >> 8, 10, PROG, 1);
  endtask
  task automatic t_write_read;
    prog_op((cmd(sep_pkg::OPC_WRITE, 7'h05, 8'hA5) << 4) | 32'hF, 22, PROG, 0);
    read_chk(7'h05, {1'h0, 8'hA5, 8'hFF});
  endtask
  task automatic t_erase;
    prog_op(cmd(sep_pkg::OPC_ERASE, 7'h05, 8'h00) >> 8, 10, PROG, 0);
    read_chk(7'h04, {1'h0, 16'hFFFF});
  endtask
  // An erase sent while the write_all cycle runs must be refused
  task automatic t_busy_cs;
    u_master.frame(cmd(sep_pkg::OPC_EXT, {sep_pkg::SUB_WRITE_ALL, 5'h00}, 8'h3C), 18);
    u_master.deselect();
    u_master.frame(cmd(sep_pkg::OPC_ERASE, 7'h10, 8'h00) >> 8, 10);
    u_master.deselect();
    wait_idle();
    chk("write_all len", WALL, blen);
    read_chk(7'h10, {1'h0, 16'h3C3C});
  endtask
  task automatic t_disable;
    u_master.frame(cmd(sep_pkg::OPC_EXT, {sep_pkg::SUB_DISABLE, 5'h00}, 8'h00) >> 8, 10);
    u_master.deselect();
    locked_write();
    read_chk(7'h05, {1'h0, 16'h3C3C});
  endtask

  initial begin
    sys_rst      = 1'h1;
    n_errors     = 0;
    total_checks = 0;
    prev_busy    = 1'h0;
    oe_seen      = 1'h0;
    blen         = 0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    settle(3);
    locked_write();
    t_enable();
    t_erase_all();
    t_write_read();
    t_erase();
    t_busy_cs();
    t_disable();
    print_verdict();
  end
endmodule
